// *** design/bst_map.vh ***
// Constants for the boundary-scan test port
`ifndef BST_MAP_VH
`define BST_MAP_VH

// Register widths and the position of the float control cell
`define BST_IR_W 3
`define BST_ID_W 32
`define BST_BSR_LEN 110
`define BST_HIZ_BIT 109

// Controller states
`define BST_S_TLR 4'h0
`define BST_S_RTI 4'h1
`define BST_S_SEL_DR 4'h2
`define BST_S_CAP_DR 4'h3
`define BST_S_SH_DR 4'h4
`define BST_S_EX1_DR 4'h5
`define BST_S_PAU_DR 4'h6
`define BST_S_EX2_DR 4'h7
`define BST_S_UPD_DR 4'h8
`define BST_S_SEL_IR 4'h9
`define BST_S_CAP_IR 4'hA
`define BST_S_SH_IR 4'hB
`define BST_S_EX1_IR 4'hC
`define BST_S_PAU_IR 4'hD
`define BST_S_EX2_IR 4'hE
`define BST_S_UPD_IR 4'hF

// Instruction codes
`define BST_I_EXTEST 3'h0
`define BST_I_IDCODE 3'h1
`define BST_I_SAMPLEZ 3'h2
`define BST_I_PRIV3 3'h3
`define BST_I_SAMPLE 3'h4
`define BST_I_PRIV5 3'h5
`define BST_I_PRIV6 3'h6
`define BST_I_BYPASS 3'h7

// Capture pattern of the instruction path
`define BST_IR_CAPT 3'h1

// Identification word, arbitrary value with the mandatory low bit set
`define BST_ID_VALUE 32'h0A5A5A5B

// Pin synchroniser reset levels, order {tdi, tms, tck}
`define BST_SYNC_RST 3'h6

`endif

// *** design/bst_sync.v ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none

module bst_sync #(
    parameter W = 3,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    input wire clk_i,
    input wire nrst_i,
    input wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);

genvar gi;
generate
    for (gi = 0; gi < W; gi = gi + 1)
    begin : g_bit
        reg s1_ff;
        reg s2_ff;
        reg s3_ff;
        reg q_ff;
        always @(posedge clk_i or negedge nrst_i)
        begin
            if (!nrst_i)
            begin
                s1_ff <= INIT[gi];
                s2_ff <= INIT[gi];
                s3_ff <= INIT[gi];
                q_ff <= INIT[gi];
            end
            else
            begin
                s1_ff <= d_i[gi];
                s2_ff <= s1_ff;
                s3_ff <= s2_ff;
                // Accept a change only once stages two and three agree
                if (s2_ff == s3_ff)
                    q_ff <= s2_ff;
            end
        end
        assign q_o[gi] = q_ff;
    end
endgenerate

endmodule
`default_nettype wire

// *** design/bst_fsm.v ***
// Test port controller state machine
`timescale 1ns/100ps
`default_nettype none
`include "bst_map.vh"

module bst_fsm (
    input wire clk_i,
    input wire nrst_i,
    input wire adv_i,
    input wire tms_i,
    output wire [3:0] state_o
);

reg [3:0] state_ff;
reg [3:0] nxt_state;

// Sixteen-state walk steered by mode select
always @*
begin
    nxt_state = state_ff;
    case (state_ff)
        `BST_S_TLR: nxt_state = tms_i ? `BST_S_TLR : `BST_S_RTI;
        `BST_S_RTI: nxt_state = tms_i ? `BST_S_SEL_DR : `BST_S_RTI;
        `BST_S_SEL_DR: nxt_state = tms_i ? `BST_S_SEL_IR : `BST_S_CAP_DR;
        `BST_S_CAP_DR: nxt_state = tms_i ? `BST_S_EX1_DR : `BST_S_SH_DR;
        `BST_S_SH_DR: nxt_state = tms_i ? `BST_S_EX1_DR : `BST_S_SH_DR;
        `BST_S_EX1_DR: nxt_state = tms_i ? `BST_S_UPD_DR : `BST_S_PAU_DR;
        `BST_S_PAU_DR: nxt_state = tms_i ? `BST_S_EX2_DR : `BST_S_PAU_DR;
        `BST_S_EX2_DR: nxt_state = tms_i ? `BST_S_UPD_DR : `BST_S_SH_DR;
        `BST_S_UPD_DR: nxt_state = tms_i ? `BST_S_SEL_DR : `BST_S_RTI;
        `BST_S_SEL_IR: nxt_state = tms_i ? `BST_S_TLR : `BST_S_CAP_IR;
        `BST_S_CAP_IR: nxt_state = tms_i ? `BST_S_EX1_IR : `BST_S_SH_IR;
        `BST_S_SH_IR: nxt_state = tms_i ? `BST_S_EX1_IR : `BST_S_SH_IR;
        `BST_S_EX1_IR: nxt_state = tms_i ? `BST_S_UPD_IR : `BST_S_PAU_IR;
        `BST_S_PAU_IR: nxt_state = tms_i ? `BST_S_EX2_IR : `BST_S_PAU_IR;
        `BST_S_EX2_IR: nxt_state = tms_i ? `BST_S_UPD_IR : `BST_S_SH_IR;
        `BST_S_UPD_IR: nxt_state = tms_i ? `BST_S_SEL_DR : `BST_S_RTI;
        default: nxt_state = `BST_S_TLR;
    endcase
end

always @(posedge clk_i or negedge nrst_i)
begin
    if (!nrst_i)
        state_ff <= `BST_S_TLR;
    else if (adv_i)
        state_ff <= nxt_state;
end

assign state_o = state_ff;

endmodule
`default_nettype wire

// *** design/bst_tap.v ***
// Boundary-scan test access port, top level
`timescale 1ns/100ps
`default_nettype none
`include "bst_map.vh"

module bst_tap #(
    parameter BSR_LEN = `BST_BSR_LEN,
    parameter HIZ_BIT = `BST_HIZ_BIT
) (
    input wire CLK_I,
    input wire NRST_I,
    input wire TCK_I,
    input wire TMS_I,
    input wire TDI_I,
    input wire [BSR_LEN-1:0] BSR_CAPTURE_I,
    output wire TDO_O,
    output wire TDO_OE_O,
    output wire TMS_PULLUP_O,
    output wire TDI_PULLUP_O,
    output wire [BSR_LEN-1:0] BSR_DATA_O,
    output wire EXTEST_O,
    output wire OUT_HIGHZ_O,
    output wire [3:0] TAP_STATE_O,
    output wire [`BST_IR_W-1:0] IR_O
);

localparam IRW = `BST_IR_W;
localparam IDW = `BST_ID_W;

wire [2:0] pins_s;
wire tck_s;
wire tms_s;
wire tdi_s;
reg tck_d_ff;
wire tck_rise;
wire tck_fall;
wire [3:0] state;

reg [IRW-1:0] ir_sr_ff;
reg [IRW-1:0] ir_ff;
reg byp_ff;
reg [IDW-1:0] id_sr_ff;
reg [BSR_LEN-1:0] bsr_sr_ff;
reg [BSR_LEN-1:0] bsr_upd_ff;
reg tdo_ff;
reg tdo_oe_ff;
reg extest_ff;
reg highz_ff;
reg nxt_highz;

reg sel_byp;
reg sel_id;
reg sel_bsr;
reg dr_lsb;
reg nxt_tdo;

wire in_tlr;
wire in_cap_ir;
wire in_sh_ir;
wire in_upd_ir;
wire in_cap_dr;
wire in_sh_dr;
wire in_upd_dr;
wire shifting;

// Port pins through the three-stage filter
bst_sync #(
    .W(3),
    .INIT(`BST_SYNC_RST)
) u_sync (
    .clk_i(CLK_I),
    .nrst_i(NRST_I),
    .d_i({TDI_I, TMS_I, TCK_I}),
    .q_o(pins_s)
);

assign tck_s = pins_s[0];
assign tms_s = pins_s[1];
assign tdi_s = pins_s[2];

// Requests pull-ups on both inputs to the pad ring
assign TMS_PULLUP_O = 1'b1;
assign TDI_PULLUP_O = 1'b1;

// Test clock edges; a clock held low yields none
always @(posedge CLK_I or negedge NRST_I)
begin
    if (!NRST_I)
        tck_d_ff <= 1'b0;
    else
        tck_d_ff <= tck_s;
end

// Edge pulses from the filtered test clock
// One system cycle each, so every edge-gated register below moves once per edge
assign tck_rise = tck_s & ~tck_d_ff;
assign tck_fall = ~tck_s & tck_d_ff;

// Controller advances on rises only
bst_fsm u_fsm (
    .clk_i(CLK_I),
    .nrst_i(NRST_I),
    .adv_i(tck_rise),
    .tms_i(tms_s),
    .state_o(state)
);

// State decodes
assign in_tlr = (state == `BST_S_TLR);
assign in_cap_ir = (state == `BST_S_CAP_IR);
assign in_sh_ir = (state == `BST_S_SH_IR);
assign in_upd_ir = (state == `BST_S_UPD_IR);
assign in_cap_dr = (state == `BST_S_CAP_DR);
assign in_sh_dr = (state == `BST_S_SH_DR);
assign in_upd_dr = (state == `BST_S_UPD_DR);

// Output enable follows the two shift states
assign shifting = in_sh_ir | in_sh_dr;

// Data register selection from the current instruction
always @*
begin
    sel_byp = 1'b0;
    sel_id = 1'b0;
    sel_bsr = 1'b0;
    case (ir_ff)
        `BST_I_IDCODE: sel_id = 1'b1;
        `BST_I_EXTEST: sel_bsr = 1'b1;
        `BST_I_SAMPLE: sel_bsr = 1'b1;
        `BST_I_SAMPLEZ: sel_bsr = 1'b1;
        `BST_I_BYPASS: sel_byp = 1'b1;
        default: sel_byp = 1'b1;
    endcase
end

// Serial output of the selected data register
always @*
begin
    dr_lsb = byp_ff;
    if (sel_id)
        dr_lsb = id_sr_ff[0];
    else if (sel_bsr)
        dr_lsb = bsr_sr_ff[0];
end

// Instruction shift path
always @(posedge CLK_I or negedge NRST_I)
begin
    if (!NRST_I)
        ir_sr_ff <= `BST_IR_CAPT;
    else if (tck_rise)
    begin
        if (in_cap_ir)
            ir_sr_ff <= `BST_IR_CAPT;
        else if (in_sh_ir)
            ir_sr_ff <= {tdi_s, ir_sr_ff[IRW-1:1]};
    end
end

// Current instruction, updated on the falling edge in update
always @(posedge CLK_I or negedge NRST_I)
begin
    if (!NRST_I)
        ir_ff <= `BST_I_IDCODE;
    else if (in_tlr)
        ir_ff <= `BST_I_IDCODE;
    else if (tck_fall && in_upd_ir)
        ir_ff <= ir_sr_ff;
end

// Bypass stage, captures low
always @(posedge CLK_I or negedge NRST_I)
begin
    if (!NRST_I)
        byp_ff <= 1'b0;
    else if (tck_rise && sel_byp)
    begin
        if (in_cap_dr)
            byp_ff <= 1'b0;
        else if (in_sh_dr)
            byp_ff <= tdi_s;
    end
end

// Identification shift register
always @(posedge CLK_I or negedge NRST_I)
begin
    if (!NRST_I)
        id_sr_ff <= `BST_ID_VALUE;
    else if (tck_rise && sel_id)
    begin
        if (in_cap_dr)
            id_sr_ff <= `BST_ID_VALUE;
        else if (in_sh_dr)
            id_sr_ff <= {tdi_s, id_sr_ff[IDW-1:1]};
    end
end

// Boundary shift register, sampled from the pad ring
always @(posedge CLK_I or negedge NRST_I)
begin
    if (!NRST_I)
        bsr_sr_ff <= {BSR_LEN{1'b0}};
    else if (tck_rise && sel_bsr)
    begin
        if (in_cap_dr)
            bsr_sr_ff <= BSR_CAPTURE_I;
        else if (in_sh_dr)
            bsr_sr_ff <= {tdi_s, bsr_sr_ff[BSR_LEN-1:1]};
    end
end

// Boundary update latch, cleared in reset state
always @(posedge CLK_I or negedge NRST_I)
begin
    if (!NRST_I)
        bsr_upd_ff <= {BSR_LEN{1'b0}};
    else if (in_tlr)
        bsr_upd_ff <= {BSR_LEN{1'b0}};
    else if (tck_fall && in_upd_dr && sel_bsr)
        bsr_upd_ff <= bsr_sr_ff;
end

// Output data and enable move on falling edges only
always @*
begin
    nxt_tdo = 1'b0;
    if (in_sh_ir)
        nxt_tdo = ir_sr_ff[0];
    else if (in_sh_dr)
        nxt_tdo = dr_lsb;
end

// Enable drops at the first fall after leaving a shift state
always @(posedge CLK_I or negedge NRST_I)
begin
    if (!NRST_I)
    begin
        tdo_ff <= 1'b0;
        tdo_oe_ff <= 1'b0;
    end
    else if (tck_fall)
    begin
        tdo_ff <= nxt_tdo;
        tdo_oe_ff <= shifting;
    end
end

assign TDO_O = tdo_ff;
assign TDO_OE_O = tdo_oe_ff;

// Output bus float request: SAMPLE Z, or EXTEST with the control cell low
always @*
begin
    nxt_highz = 1'b0;
    if (ir_ff == `BST_I_SAMPLEZ)
        nxt_highz = 1'b1;
    else if (ir_ff == `BST_I_EXTEST)
        nxt_highz = ~bsr_upd_ff[HIZ_BIT];
end

// Pad ring controls, registered so the ring sees no decode glitches
always @(posedge CLK_I or negedge NRST_I)
begin
    if (!NRST_I)
    begin
        extest_ff <= 1'b0;
        highz_ff <= 1'b0;
    end
    else
    begin
        extest_ff <= (ir_ff == `BST_I_EXTEST);
        highz_ff <= nxt_highz;
    end
end

// Pad ring outputs
assign BSR_DATA_O = bsr_upd_ff;
assign EXTEST_O = extest_ff;
assign OUT_HIGHZ_O = highz_ff;
assign TAP_STATE_O = state;
assign IR_O = ir_ff;

endmodule
`default_nettype wire

// *** sim/bst_tap_assertions.sv ***
// Pin-level checker for the boundary-scan test port
`timescale 1ns/100ps
`default_nettype none
`include "bst_map.vh"
module bst_tap_assertions (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic TCK_I,
    input wire logic TDO_O,
    input wire logic TDO_OE_O,
    input wire logic TMS_PULLUP_O,
    input wire logic TDI_PULLUP_O,
    input wire logic [3:0] TAP_STATE_O,
    input wire logic [`BST_IR_W-1:0] IR_O
);
    logic tck_ff;
    logic [3:0] rise_ff;
    logic [3:0] fall_ff;
    // Cycles since the last test clock edge, saturating
    always @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            tck_ff <= 1'b0;
            rise_ff <= 4'hF;
            fall_ff <= 4'hF;
        end
        else
        begin
            tck_ff <= TCK_I;
            rise_ff <= (TCK_I && !tck_ff) ? 4'h0 : rise_ff + {3'h0, rise_ff != 4'hF};
            fall_ff <= (!TCK_I && tck_ff) ? 4'h0 : fall_ff + {3'h0, fall_ff != 4'hF};
        end
    end
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!NRST_I);
    state_on_rise_a: assert property ($changed(TAP_STATE_O) |-> rise_ff inside {[2:8]})
        else $error("controller state moved away from a test clock rise");
    tdo_on_fall_a: assert property ($changed(TDO_O) |-> fall_ff inside {[2:8]})
        else $error("test data out moved away from a test clock fall");
    oe_shift_only_a: assert property (TDO_OE_O |-> TAP_STATE_O inside
        {`BST_S_SH_DR, `BST_S_EX1_DR, `BST_S_SH_IR, `BST_S_EX1_IR})
        else $error("test data out driven outside shifting");
    oe_idle_off_a: assert property (TAP_STATE_O inside {`BST_S_TLR, `BST_S_RTI,
        `BST_S_PAU_DR, `BST_S_PAU_IR, `BST_S_UPD_DR, `BST_S_UPD_IR} |-> !TDO_OE_O)
        else $error("test data out not floating while idle");
    ir_reset_a: assert property (TAP_STATE_O == `BST_S_TLR |=> IR_O == `BST_I_IDCODE)
        else $error("instruction not identification in reset state");
    tlr_exit_a: assert property ($changed(TAP_STATE_O) && $past(TAP_STATE_O) == `BST_S_TLR
        |-> TAP_STATE_O == `BST_S_RTI)
        else $error("illegal exit from reset state");
    ir_capture_a: assert property ($rose(TDO_OE_O) && TAP_STATE_O == `BST_S_SH_IR
        |-> TDO_O)
        else $error("instruction capture pattern wrong");
    bypass_zero_a: assert property ($rose(TDO_OE_O) && TAP_STATE_O == `BST_S_SH_DR
        && IR_O inside {3'h3, 3'h5, 3'h6, 3'h7} |-> !TDO_O)
        else $error("bypass stage did not capture zero");
    pullups_on_a: assert property (TMS_PULLUP_O && TDI_PULLUP_O)
        else $error("pin pull-up request missing");
    cover property ($rose(TDO_OE_O) && TAP_STATE_O == `BST_S_SH_IR);
    cover property ($rose(TDO_OE_O) && TAP_STATE_O == `BST_S_SH_DR);
    cover property ($changed(TAP_STATE_O) && TAP_STATE_O == `BST_S_TLR);
endmodule
bind bst_tap bst_tap_assertions u_chk (.CLK_I(CLK_I), .NRST_I(NRST_I), .TCK_I(TCK_I),
    .TDO_O(TDO_O), .TDO_OE_O(TDO_OE_O), .TMS_PULLUP_O(TMS_PULLUP_O),
    .TDI_PULLUP_O(TDI_PULLUP_O), .TAP_STATE_O(TAP_STATE_O), .IR_O(IR_O));
`default_nettype wire

// *** sim/bst_ctl_model.sv ***
// Behavioural external test controller for the scan port
`timescale 1ns/100ps
`default_nettype none
module bst_ctl_model (
    input wire logic clk_i,
    input wire logic tdo_i,
    input wire logic tdo_oe_i,
    input wire logic tms_pu_i,
    input wire logic tdi_pu_i,
    output wire logic tck_o,
    output wire logic tms_o,
    output wire logic tdi_o
);
    logic drv = 1'b0;
    logic tck_ff = 1'b0;
    logic tms_ff = 1'b1;
    logic tdi_ff = 1'b1;
    logic last_ff = 1'b0;
    assign tck_o = tck_ff;
    assign tms_o = drv ? tms_ff : tms_pu_i;
    assign tdi_o = drv ? tdi_ff : tdi_pu_i;
    always @(posedge clk_i)
    begin
        if (tdo_oe_i)
            last_ff <= tdo_i;
    end
    // One test clock period: low then high, data out read late in high
    task automatic step(input logic ms, input logic di, output logic bit_o);
    begin
        drv <= 1'b1;
        tck_ff <= 1'b0;
        tms_ff <= ms;
        tdi_ff <= di;
        repeat (4) @(posedge clk_i);
        tck_ff <= 1'b1;
        repeat (4) @(posedge clk_i);
        bit_o = tdo_oe_i ? tdo_i : ~last_ff;
    end
    endtask
    // Unused port: clock stands low, pins released
    task automatic idle(input int n);
    begin
        drv <= 1'b0;
        tck_ff <= 1'b0;
        repeat (n) @(posedge clk_i);
    end
    endtask
endmodule
`default_nettype wire

// *** sim/test_bst_tap.sv ***
// Self-checking bench for the boundary-scan test port
`timescale 1ns/100ps
`default_nettype none
`include "bst_map.vh"
module test_bst_tap;
    localparam int LEN = `BST_BSR_LEN;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [LEN-1:0] cap = '0;
    logic [LEN-1:0] din;
    logic [LEN-1:0] dout;
    logic b;
    wire tck, tms, tdi, tdo, tdo_oe, tms_pu, tdi_pu, extest, highz;
    wire [LEN-1:0] bsr;
    wire [3:0] st;
    wire [2:0] ir;
    int bad_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int seed = 84516;
    bst_tap u_dut (.CLK_I(clk), .NRST_I(nrst), .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi),
        .BSR_CAPTURE_I(cap), .TDO_O(tdo), .TDO_OE_O(tdo_oe), .TMS_PULLUP_O(tms_pu),
        .TDI_PULLUP_O(tdi_pu), .BSR_DATA_O(bsr), .EXTEST_O(extest), .OUT_HIGHZ_O(highz),
        .TAP_STATE_O(st), .IR_O(ir));
    bst_ctl_model u_ctl (.clk_i(clk), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .tms_pu_i(tms_pu),
        .tdi_pu_i(tdi_pu), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));
    initial
    begin
        forever #10 clk = ~clk;
    end
    task automatic complete_run();
    begin
        if (bad_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 12000)
        begin
            bad_count = bad_count + 1;
            complete_run();
        end
    end
    task automatic chk(input logic [LEN-1:0] got, input logic [LEN-1:0] exp);
    begin
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    function automatic logic [LEN-1:0] rnd();
        return LEN'({$random(seed), $random(seed), $random(seed), $random(seed)});
    endfunction
    function automatic int dr_len(input logic [2:0] c);
        if (c == `BST_I_IDCODE)
            return 32;
        if (c inside {`BST_I_EXTEST, `BST_I_SAMPLEZ, `BST_I_SAMPLE})
            return LEN;
        return 4;
    endfunction
    // Bypass paths delay the stream by one stage behind a captured zero
    function automatic logic [LEN-1:0] dr_exp(input logic [2:0] c, input logic [LEN-1:0] d);
        logic [LEN-1:0] r;
        r = {d[LEN-2:0], 1'b0};
        if (c == `BST_I_IDCODE)
            r = LEN'(`BST_ID_VALUE);
        if (dr_len(c) == LEN)
            r = cap;
        return r & ({LEN{1'b1}} >> (LEN - dr_len(c)));
    endfunction
    // From idle: select, capture, shift n bits, update, back to idle
    task automatic scan(input logic ir_path, input int n, input logic [LEN-1:0] d);
    begin
        dout = '0;
        u_ctl.step(1'b1, 1'b1, b);
        if (ir_path)
            u_ctl.step(1'b1, 1'b1, b);
        u_ctl.step(1'b0, 1'b1, b);
        u_ctl.step(1'b0, 1'b1, b);
        for (int i = 0; i < n; i++)
        begin
            u_ctl.step(i == n - 1, d[i], b);
            dout[i] = b;
        end
        u_ctl.step(1'b1, 1'b1, b);
        u_ctl.step(1'b0, 1'b1, b);
    end
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        chk(st, `BST_S_TLR);
        chk(ir, `BST_I_IDCODE);
        chk(tdo_oe, 1'b0);
        chk({tms, tdi}, 2'h3);
        u_ctl.step(1'b0, 1'b1, b);
        din = rnd();
        scan(1'b0, 32, din);
        chk(dout, dr_exp(`BST_I_IDCODE, din));
        for (int c = 0; c < 8; c++)
        begin
            scan(1'b1, 3, LEN'(c));
            chk(dout, LEN'(`BST_IR_CAPT));
            chk(ir, c[2:0]);
            cap <= rnd();
            din = rnd();
            scan(1'b0, dr_len(c[2:0]), din);
            chk(dout, dr_exp(c[2:0], din));
            if (dr_len(c[2:0]) == LEN)
                chk(bsr, din);
            chk(extest, c == 0);
            chk(highz, c == 2 || (c == 0 && !din[`BST_HIZ_BIT]));
        end
        u_ctl.step(1'b1, 1'b1, b);
        u_ctl.step(1'b0, 1'b1, b);
        u_ctl.step(1'b0, 1'b1, b);
        repeat (5) u_ctl.step(1'b1, 1'b1, b);
        repeat (4) @(posedge clk);
        chk(st, `BST_S_TLR);
        chk(ir, `BST_I_IDCODE);
        u_ctl.step(1'b0, 1'b1, b);
        u_ctl.idle(40);
        chk(st, `BST_S_RTI);
        u_ctl.step(1'b1, 1'b0, b);
        u_ctl.step(1'b0, 1'b0, b);
        repeat (2) u_ctl.step(1'b0, 1'b0, b);
        nrst <= 1'b0;
        @(posedge clk);
        chk(tdo_oe, 1'b0);
        chk(st, `BST_S_TLR);
        nrst <= 1'b1;
        u_ctl.idle(8);
        complete_run();
    end
endmodule
`default_nettype wire
